// ===== include/sfhi_pkg.sv
// Constants, types and functional notes for the serial flash host front end
// Functional notes
// - Select high deselects, goes to standby, serial output released to high impedance.
// - While deselected, serial input activity is ignored entirely.
// - Select falling starts each operation, select rising ends it.
// - Standby after select rise waits until the self-timed operation completes.
// - Command, address and write bits are captured on serial clock rising edges.
// - Serial output changes to the next bit on serial clock falling edges.
// - One serial input carries opcode, address and data alike.
// - Works with host clock mode 0 or mode 3.
// - Main array is 4096 pages of 512 or 528 bytes, selectable.
// - Two page-sized buffers; one may fill while the array programs.
// - Program and erase timing is internal, needing no serial clocks.
// - Erase units are page, 4 KB block, 128 KB sector and whole chip.
// - 128-byte security register: 64 bytes user area, 64 bytes fixed identifier.
// - 8-bit opcode then address follow select fall, all most significant bit first.
package sfhi_pkg;
	localparam int OPCODE_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int HEADER_BITS = OPCODE_BITS + ADDR_BITS;
	localparam int PAGE_COUNT = 4096;
	localparam int PAGE_BITS = 12;
	localparam int OFFSET_BITS = 10;
	localparam int PAGE_BYTES_STD = 512;
	localparam int PAGE_BYTES_EXT = 528;
	localparam int BLOCK_BYTES = 4096;
	localparam int SECTOR_BYTES = 131072;
	localparam int PAGES_PER_BLOCK_LOG2 = 3;
	localparam int PAGES_PER_SECTOR_LOG2 = 8;
	localparam int BLOCK_BITS = PAGE_BITS - PAGES_PER_BLOCK_LOG2;
	localparam int SECTOR_BITS = PAGE_BITS - PAGES_PER_SECTOR_LOG2;
	localparam int SEC_REG_BYTES = 128;
	localparam int SEC_USER_BYTES = 64;
	localparam int SEC_ID_BYTES = 64;
	localparam int BUFFER_COUNT = 2;
	localparam int HOST_SCK_MAX_MHZ = 66;
	localparam int SYS_CLK_MHZ = 50;
	localparam logic [9:0] LAST_STD = 10'h1ff;
	localparam logic [9:0] LAST_EXT = 10'h20f;
	localparam logic [2:0] SYNC_IDLE = 3'h7;

	typedef enum logic [1:0] {ST_DESEL, ST_HEADER, ST_DATA} sfhi_state_e;

	// Operation handed to the program, erase and buffer engines
	typedef struct packed {
		logic [OPCODE_BITS-1:0] opcode;
		logic [ADDR_BITS-1:0] addr;
		logic [PAGE_BITS-1:0] page;
		logic [OFFSET_BITS-1:0] offset;
		logic [BLOCK_BITS-1:0] block;
		logic [SECTOR_BITS-1:0] sector;
		logic secUser;
		logic [6:0] secOffset;
	} sfhi_cmd_s;

	// Synchronised pin levels: select, clock, data
	typedef struct packed {
		logic csN;
		logic sck;
		logic si;
	} sfhi_pins_s;
endpackage

// ===== rtl/sfhi_front_end.sv
// Serial flash host front end: pin sampling, framing, shifting, engine hand-off
`timescale 1ns/1ns
module sfhi_front_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic csN,
	input wire logic sck,
	input wire logic si,
	output logic soOut,
	output logic soOe_n,
	input wire logic pageSize528,
	input wire logic engineBusy,
	input wire logic [7:0] rdByte,
	output logic cmdValid,
	output sfhi_pkg::sfhi_cmd_s cmd,
	output logic wrValid,
	output logic [7:0] wrByte,
	output logic [9:0] wrOffset,
	output logic rdReq,
	output logic frameStart,
	output logic frameEnd,
	output logic standby
);
	sfhi_pkg::sfhi_pins_s sync1, sync2, last;
	sfhi_pkg::sfhi_pins_s next_sync1, next_sync2, next_last;
	sfhi_pkg::sfhi_state_e state, next_state;
	sfhi_pkg::sfhi_cmd_s next_cmd;
	logic [sfhi_pkg::HEADER_BITS-1:0] header, next_header;
	logic [5:0] bitCnt, next_bitCnt;
	logic [7:0] inShift, next_inShift;
	logic [7:0] outShift, next_outShift;
	logic loadPend, next_loadPend;
	logic [9:0] offset, next_offset;
	logic next_soOut, next_soOe_n, next_cmdValid, next_wrValid, next_rdReq;
	logic [7:0] next_wrByte;
	logic [9:0] next_wrOffset;
	logic next_frameStart, next_frameEnd, next_standby;
	logic sckRise, sckFall, csFall, csRise;
	logic [9:0] lastOffset;
	logic [sfhi_pkg::HEADER_BITS-1:0] fullHeader;
	sfhi_pkg::sfhi_cmd_s hdrCmd;
	logic [sfhi_pkg::PAGE_BITS-1:0] hdrPage;
	logic [sfhi_pkg::OFFSET_BITS-1:0] hdrOffset;

	// Two-stage synchronisers; only the second stage feeds logic
	// Each serial clock phase must span three system clocks to be seen
	always_comb begin
		next_sync1 = '{csN: csN, sck: sck, si: si};
		next_sync2 = sync1;
		next_last = sync2;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1 <= sfhi_pkg::SYNC_IDLE;
			sync2 <= sfhi_pkg::SYNC_IDLE;
			last <= sfhi_pkg::SYNC_IDLE;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			last <= next_last;
		end
	end

	// Edges are taken from the idle-agnostic level history
	assign sckRise = sync2.sck && !last.sck;
	assign sckFall = !sync2.sck && last.sck;
	assign csFall = !sync2.csN && last.csN;
	assign csRise = sync2.csN && !last.csN;
	assign lastOffset = pageSize528 ? sfhi_pkg::LAST_EXT : sfhi_pkg::LAST_STD;
	assign fullHeader = {header[sfhi_pkg::HEADER_BITS-2:0], sync2.si};

	// The wider page keeps one more offset bit, so the page field slides by one
	always_comb begin
		if (pageSize528) begin
			hdrPage = fullHeader[sfhi_pkg::OFFSET_BITS +: sfhi_pkg::PAGE_BITS];
			hdrOffset = fullHeader[sfhi_pkg::OFFSET_BITS-1:0];
		end else begin
			hdrPage = fullHeader[sfhi_pkg::OFFSET_BITS-1 +: sfhi_pkg::PAGE_BITS];
			hdrOffset = {1'b0, fullHeader[sfhi_pkg::OFFSET_BITS-2:0]};
		end
	end

	// Operation record offered to the engines when the last header bit arrives
	always_comb begin
		hdrCmd.opcode = fullHeader[sfhi_pkg::HEADER_BITS-1 -: sfhi_pkg::OPCODE_BITS];
		hdrCmd.addr = fullHeader[sfhi_pkg::ADDR_BITS-1:0];
		hdrCmd.page = hdrPage;
		hdrCmd.offset = hdrOffset;
		hdrCmd.block = hdrPage[sfhi_pkg::PAGE_BITS-1:sfhi_pkg::PAGES_PER_BLOCK_LOG2];
		hdrCmd.sector = hdrPage[sfhi_pkg::PAGE_BITS-1:sfhi_pkg::PAGES_PER_SECTOR_LOG2];
		hdrCmd.secUser = fullHeader[6:0] < 7'(sfhi_pkg::SEC_USER_BYTES);
		hdrCmd.secOffset = fullHeader[6:0];
	end

	always_comb begin
		next_state = state;
		next_header = header;
		next_bitCnt = bitCnt;
		next_inShift = inShift;
		next_outShift = outShift;
		next_loadPend = 1'b0;
		next_offset = offset;
		next_soOut = soOut;
		next_soOe_n = soOe_n;
		next_cmd = cmd;
		next_cmdValid = 1'b0;
		next_wrValid = 1'b0;
		next_wrByte = wrByte;
		next_wrOffset = wrOffset;
		next_rdReq = 1'b0;
		next_frameStart = 1'b0;
		next_frameEnd = 1'b0;
		// Engine owns self-timed work; standby only once it is idle
		next_standby = (state == sfhi_pkg::ST_DESEL) && !engineBusy;
		if (loadPend) begin
			next_outShift = rdByte;
		end
		case (state)
			sfhi_pkg::ST_DESEL: begin
				next_soOe_n = 1'b1;
				// Clock and data ignored until select falls
				if (csFall) begin
					next_state = sfhi_pkg::ST_HEADER;
					next_bitCnt = 6'h00;
					next_frameStart = 1'b1;
				end
			end
			sfhi_pkg::ST_HEADER: begin
				if (csRise) begin
					next_state = sfhi_pkg::ST_DESEL;
					next_frameEnd = 1'b1;
					next_soOe_n = 1'b1;
				end else if (sckRise) begin
					next_header = fullHeader;
					next_bitCnt = bitCnt + 6'h01;
					if (bitCnt == 6'(sfhi_pkg::HEADER_BITS - 1)) begin
						next_state = sfhi_pkg::ST_DATA;
						next_bitCnt = 6'h00;
						next_cmdValid = 1'b1;
						next_cmd = hdrCmd;
						next_offset = hdrOffset;
						// Engine answers on the next clock, well before the first falling edge
						next_rdReq = 1'b1;
						next_loadPend = 1'b1;
					end
				end
			end
			sfhi_pkg::ST_DATA: begin
				// Driven through the whole data phase; opcodes are not decoded here
				next_soOe_n = 1'b0;
				if (csRise) begin
					next_state = sfhi_pkg::ST_DESEL;
					next_frameEnd = 1'b1;
					next_soOe_n = 1'b1;
				end else if (sckRise) begin
					next_inShift = {inShift[6:0], sync2.si};
					next_bitCnt = 6'({3'h0, bitCnt[2:0] + 3'h1});
					if (bitCnt[2:0] == 3'h7) begin
						next_wrValid = 1'b1;
						next_wrByte = {inShift[6:0], sync2.si};
						next_wrOffset = offset;
						// Buffer pointer wraps at the page end
						next_offset = (offset == lastOffset) ? 10'h000 : offset + 10'h001;
						next_rdReq = 1'b1;
						next_loadPend = 1'b1;
					end
				end else if (sckFall) begin
					next_soOut = outShift[7];
					next_outShift = {outShift[6:0], 1'b0};
				end
			end
			default: begin
				next_state = sfhi_pkg::ST_DESEL;
				next_soOe_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= sfhi_pkg::ST_DESEL;
			header <= '0;
			bitCnt <= 6'h00;
			inShift <= 8'h00;
			outShift <= 8'h00;
			loadPend <= 1'b0;
			offset <= 10'h000;
			soOut <= 1'b0;
			soOe_n <= 1'b1;
			cmd <= '0;
			cmdValid <= 1'b0;
			wrValid <= 1'b0;
			wrByte <= 8'h00;
			wrOffset <= 10'h000;
			rdReq <= 1'b0;
			frameStart <= 1'b0;
			frameEnd <= 1'b0;
			standby <= 1'b0;
		end else begin
			state <= next_state;
			header <= next_header;
			bitCnt <= next_bitCnt;
			inShift <= next_inShift;
			outShift <= next_outShift;
			loadPend <= next_loadPend;
			offset <= next_offset;
			soOut <= next_soOut;
			soOe_n <= next_soOe_n;
			cmd <= next_cmd;
			cmdValid <= next_cmdValid;
			wrValid <= next_wrValid;
			wrByte <= next_wrByte;
			wrOffset <= next_wrOffset;
			rdReq <= next_rdReq;
			frameStart <= next_frameStart;
			frameEnd <= next_frameEnd;
			standby <= next_standby;
		end
	end
endmodule // sfhi_front_end

// ===== bench/sfhi_front_end_checker.sv
// Port-level protocol assertions for the front end
`timescale 1ns/1ns
module sfhi_front_end_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic csN,
	input wire logic sck,
	input wire logic soOut,
	input wire logic soOe_n,
	input wire logic engineBusy,
	input wire logic cmdValid,
	input wire logic wrValid,
	input wire logic frameStart,
	input wire logic frameEnd,
	input wire logic standby
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_desel; csN[*5] |-> soOe_n && !cmdValid && !wrValid; endproperty
	a_desel: assert property (p_desel) else $error("active while deselected");
	property p_start; $fell(csN) |-> ##[1:3] frameStart; endproperty
	a_start: assert property (p_start) else $error("no frame start");
	property p_end; $rose(csN) |-> ##[1:3] frameEnd; endproperty
	a_end: assert property (p_end) else $error("no frame end");
	property p_so;
		$changed(soOut) && !soOe_n && !$past(soOe_n) |->
			!($past(sck) && $past(sck, 2) && $past(sck, 3));
	endproperty
	a_so: assert property (p_so) else $error("output moved without clock fall");
	property p_rise; cmdValid || wrValid |-> sck && $past(sck); endproperty
	a_rise: assert property (p_rise) else $error("capture without clock rise");
	property p_drive; cmdValid |-> ##[1:2] !soOe_n; endproperty
	a_drive: assert property (p_drive) else $error("output not driven");
	property p_idle; standby |-> !$past(engineBusy); endproperty
	a_idle: assert property (p_idle) else $error("standby while busy");
	property p_stand; !csN[*5] |-> !standby; endproperty
	a_stand: assert property (p_stand) else $error("standby while selected");
	c_cmd: cover property (cmdValid);
	c_wr: cover property (wrValid);
	c_end: cover property (frameEnd);
endmodule // sfhi_front_end_checker
bind sfhi_front_end sfhi_front_end_checker chk_u (.sys_clk, .rst_n, .csN, .sck, .soOut,
	.soOe_n, .engineBusy, .cmdValid, .wrValid, .frameStart, .frameEnd, .standby);

// ===== bench/sfhi_host_model.sv
// Host model: frames transfers in clock mode 0 or 3
`timescale 1ns/1ns
module sfhi_host_model (
	input wire logic sys_clk,
	input wire logic soOut,
	output logic csN,
	output logic sck,
	output logic si
);
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Data line wanders while idle so stale bits never look valid
	always @(posedge sys_clk) if (csN) si <= ~si;
	task automatic xfer(input logic mode3, input logic [47:0] bits, output logic [15:0] rx);
		sck <= mode3;
		@(posedge sys_clk);
		csN <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = 47; i >= 0; i--) begin
			sck <= 1'b0;
			si <= bits[i];
			repeat (4) @(posedge sys_clk);
			sck <= 1'b1;
			if (i < 16) rx[i] = soOut;
			repeat (4) @(posedge sys_clk);
		end
		sck <= mode3;
		repeat (4) @(posedge sys_clk);
		csN <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule // sfhi_host_model

// ===== bench/sfhi_front_end_tb.sv
// Testbench: random framed transfers in both clock modes
`timescale 1ns/1ns
module sfhi_front_end_tb;
	logic sys_clk = 0, rst_n = 0, pageSize528 = 0, engineBusy = 0;
	logic csN, sck, si, soOut, soOe_n, cmdValid, wrValid, standby, rdReq, psz, busy;
	logic [7:0] rdByte = 8'h00, wrByte;
	logic [15:0] got, d;
	logic [9:0] wrOffset, of, lastOf;
	logic [11:0] pg;
	logic [31:0] expQ[$], hdr;
	sfhi_pkg::sfhi_cmd_s cmd;
	int mismatches = 0, checksDone = 0;
	sfhi_front_end dut_u (.sys_clk, .rst_n, .csN, .sck, .si, .soOut, .soOe_n, .pageSize528,
		.engineBusy, .rdByte, .cmdValid, .cmd, .wrValid, .wrByte, .wrOffset, .rdReq,
		.frameStart(), .frameEnd(), .standby);
	sfhi_host_model host_u (.sys_clk, .soOut, .csN, .sck, .si);
	initial forever #10 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checksDone++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic take(input logic [31:0] g);
		if (expQ.size() == 0) begin
			mismatches++;
			$display("unexpected at %0t: result with nothing expected", $time);
		end else begin
			chk(g, expQ.pop_front());
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		if (cmdValid) begin
			take({cmd.opcode, cmd.addr});
			take(32'({cmd.page, cmd.offset}));
			take(32'({cmd.block, cmd.sector, cmd.secUser, cmd.secOffset}));
			chk(32'(rdReq), 32'h1);
		end
		if (wrValid) begin
			take(32'(wrByte));
			take(32'(wrOffset));
			chk(32'(rdReq), 32'h1);
		end
	end
	initial begin
		void'($urandom(34687));
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			hdr = $urandom();
			d = 16'($urandom());
			psz = i[1];
			busy = (i == 5);
			lastOf = psz ? sfhi_pkg::LAST_EXT : sfhi_pkg::LAST_STD;
			// Frames 4 to 7 start on the last byte of the page to force a wrap
			if (i[2]) hdr[9:0] = psz ? lastOf : {hdr[9], lastOf[8:0]};
			else if (psz) hdr[9:0] = 10'($urandom_range(527));
			pg = psz ? hdr[21:10] : hdr[20:9];
			of = psz ? hdr[9:0] : {1'b0, hdr[8:0]};
			pageSize528 <= psz;
			rdByte <= 8'($urandom());
			engineBusy <= busy;
			expQ.push_back(hdr);
			expQ.push_back(32'({pg, of}));
			expQ.push_back(32'({9'(pg / (sfhi_pkg::BLOCK_BYTES / sfhi_pkg::PAGE_BYTES_STD)),
				4'(pg / (sfhi_pkg::SECTOR_BYTES / sfhi_pkg::PAGE_BYTES_STD)),
				hdr[6:0] < 7'(sfhi_pkg::SEC_USER_BYTES), hdr[6:0]}));
			expQ.push_back(32'(d[15:8]));
			expQ.push_back(32'(of));
			expQ.push_back(32'(d[7:0]));
			expQ.push_back(32'((of == lastOf) ? 10'h000 : of + 10'h001));
			@(posedge sys_clk);
			host_u.xfer(i[0], {hdr, d}, got);
			chk(32'(got), 32'({rdByte, rdByte}));
			chk(32'(soOe_n), 32'h1);
			chk(32'(standby), 32'(!busy));
			if (busy) begin
				engineBusy <= 1'b0;
				repeat (2) @(posedge sys_clk);
				chk(32'(standby), 32'h1);
			end
		end
		chk(32'(expQ.size()), 32'h0);
		report_and_stop();
	end
endmodule // sfhi_front_end_tb
